// ===== verilog/pwr_pkg.sv
// constants, field layouts and carrier types of the power-mode and wake controller
// assumes a 100 MHz block clock and an 8-bit special-function register port
package pwr_pkg;

  localparam logic [7:0] PWRCTL_ADDR  = 8'h87;
  localparam logic [7:0] CLKMUL_ADDR  = 8'hD7;
  localparam logic [7:0] IDENT_ADDR   = 8'hC2;

  localparam int PWRCTL_IDLE_BIT   = 0;
  localparam int PWRCTL_PD_BIT     = 1;
  localparam int PWRCTL_SPIWK_BIT  = 5;
  localparam int PWRCTL_INT0WK_BIT = 6;
  localparam logic [7:0] PWRCTL_RESET = 8'h00;

  localparam int PLL_CD_LSB      = 0;
  localparam int PLL_LOCK_BIT    = 6;
  localparam int PLL_OSCPD_BIT   = 7;
  localparam logic [2:0] PLL_CD_RESET = 3'h3;
  localparam logic       OSCPD_RESET  = 1'b0;

  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_FREQ_HZ   = 100000000;
  localparam int OSC_FREQ_HZ   = 32768;
  localparam int PLL_MULT      = 384;
  localparam int PLL_FREQ_HZ   = OSC_FREQ_HZ * PLL_MULT;

  localparam int POR_TIME_MS      = 128;
  localparam int LOCK_TIME_MS     = 1;
  localparam int OSC_START_MS     = 150;
  localparam int POR_CYCLES       = POR_TIME_MS * (1000000 / CLK_PERIOD_NS);
  localparam int LOCK_CYCLES      = LOCK_TIME_MS * (1000000 / CLK_PERIOD_NS);
  localparam int OSC_START_CYCLES = OSC_START_MS * (1000000 / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_POR    = 3'b000,
    ST_RESET  = 3'b001,
    ST_NORMAL = 3'b010,
    ST_IDLE   = 3'b011,
    ST_PDOWN  = 3'b100
  } pmode_e;

  typedef struct packed {
    logic int0_wake;
    logic serial_wake;
    logic [2:0] spare;
    logic pdown;
    logic idle;
  } pwrctl_s;

  typedef struct packed {
    logic oscillator_powerdown_bit;
    logic [2:0] core_div;
  } clkmul_s;

  typedef struct packed {
    logic pstrb_o;
    logic pstrb_oe_n;
    logic ale_o;
    logic dac_oe_n;
    logic port_hold;
  } pins_s;

endpackage

// ===== verilog/rate_tick.sv
// fractional-rate tick generator by phase accumulation
// assumes INC below MODULUS; tick is registered
`timescale 1ns/100ps
module rate_tick #(
  parameter int INC     = 1,
  parameter int MODULUS = 2
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick
);

  logic [31:0] acc_r;
  logic [32:0] sum;

  if (INC < 1 || INC >= MODULUS)
  begin : g_chk
    $error("rate_tick: INC out of range");
  end

  assign sum = {1'b0, acc_r} + 33'(INC);

  always_ff @(posedge clk)
  begin
    if (rst || !run)
    begin
      acc_r <= 32'h0;
      tick  <= 1'b0;
    end
    else if (sum >= 33'(MODULUS))
    begin
      acc_r <= 32'(sum - 33'(MODULUS));
      tick  <= 1'b1;
    end
    else
    begin
      acc_r <= sum[31:0];
      tick  <= 1'b0;
    end
  end

endmodule

// ===== verilog/power_mode_wake_control.sv
// power-mode sequencer: normal, idle, power-down, wake-up, lock and reset strap
// assumes core, interrupt sources and converter logic share CLOCK; pins are raw
`timescale 1ns/100ps
module power_mode_wake_control #(
  parameter int POR_CNT       = pwr_pkg::POR_CYCLES,
  parameter int LOCK_CNT      = pwr_pkg::LOCK_CYCLES,
  parameter int OSC_START_CNT = pwr_pkg::OSC_START_CYCLES,
  parameter logic [3:0] FAMILY_CODE = 4'hA, // arbitrary value
  parameter logic [3:0] REVISION    = 4'h1
) (
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic       SUPPLY_OK,
  input  wire logic       RESET_PIN,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic [7:0] SFR_WDATA,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  output logic [7:0]      SFR_RDATA,
  input  wire logic       IRQ_PENDING,
  input  wire logic       INTV_EN,
  input  wire logic       INTV_IRQ,
  input  wire logic       SPI_IRQ_EN,
  input  wire logic       SPI_IRQ,
  input  wire logic       INT0_IRQ_EN,
  input  wire logic       INT0_IRQ,
  input  wire logic       CORE_PSTRB,
  input  wire logic       CORE_ALE,
  input  wire logic       PSTRB_I,
  output logic            PSTRB_O,
  output logic            PSTRB_OE_N,
  output logic            ALE_O,
  output logic            DAC_OE_N,
  output logic            PORT_HOLD,
  output logic            CORE_RST,
  output logic            CORE_CLK_EN,
  output logic            PERIPH_CLK_EN,
  output logic            OSC_TICK,
  output logic            OSC_RUN,
  output logic            PLL_RUN,
  output logic            PLL_LOCK,
  output logic            WAKE_PULSE,
  output logic            DOWNLOAD_MODE,
  output logic [2:0]      MODE
);

  localparam int PW = $clog2(POR_CNT + 1);
  localparam int LW = $clog2(LOCK_CNT + 1);
  localparam int OW = $clog2(OSC_START_CNT + 1);

  if (POR_CNT < 1 || LOCK_CNT < 1 || OSC_START_CNT < 1)
  begin : g_chk
    $error("power_mode_wake_control: counts must be at least one cycle");
  end

  // pin synchronisers
  logic [1:0] supply_sync_r;
  logic [1:0] reset_sync_r;
  logic [1:0] pstrb_sync_r;
  logic       supply_ok;
  logic       reset_pin;
  logic       pstrb_in;

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      supply_sync_r <= 2'h0;
      reset_sync_r  <= 2'h0;
      pstrb_sync_r  <= 2'h3;
    end
    else
    begin
      supply_sync_r <= {supply_sync_r[0], SUPPLY_OK};
      reset_sync_r  <= {reset_sync_r[0], RESET_PIN};
      pstrb_sync_r  <= {pstrb_sync_r[0], PSTRB_I};
    end
  end

  assign supply_ok = supply_sync_r[1];
  assign reset_pin = reset_sync_r[1];
  assign pstrb_in  = pstrb_sync_r[1];

  pwr_pkg::pmode_e  state_r;
  pwr_pkg::pmode_e  state_nxt;
  pwr_pkg::pwrctl_s pwrctl_r;
  pwr_pkg::clkmul_s clkmul_r;
  logic [PW-1:0]    por_cnt_r;
  logic [LW-1:0]    lock_cnt_r;
  logic [OW-1:0]    osc_cnt_r;
  logic             osc_stable_r;
  logic             lock_r;
  logic             download_r;
  logic             core_rst_r;
  logic [7:0]       rdata_r;
  logic [7:0]       div_cnt_r;
  logic             core_en_r;
  logic             periph_en_r;
  logic             wake_r;
  pwr_pkg::pins_s   pins_r;
  logic             pll_tick;
  logic             osc_tick;
  logic             osc_on;
  logic             pll_on;
  logic             in_reset;
  logic             pwrctl_wr;
  logic             clkmul_wr;
  logic             pd_wake;
  logic             idle_wake;
  logic             wake;

  function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] ref_a);
    sfr_hit = (a == ref_a);
  endfunction

  assign in_reset  = (state_r == pwr_pkg::ST_POR) || (state_r == pwr_pkg::ST_RESET);
  assign pwrctl_wr = SFR_WR && sfr_hit(SFR_ADDR, pwr_pkg::PWRCTL_ADDR);
  assign clkmul_wr = SFR_WR && sfr_hit(SFR_ADDR, pwr_pkg::CLKMUL_ADDR);

  // oscillator halts in power-down only with its power-down bit set
  assign osc_on = !((state_r == pwr_pkg::ST_PDOWN) && clkmul_r.oscillator_powerdown_bit) && supply_ok;
  // multiplier stopped in power-down, running in idle
  assign pll_on = osc_on && (state_r != pwr_pkg::ST_PDOWN);

  // oscillator rate and multiplied rate
  rate_tick #(
    .INC     (pwr_pkg::OSC_FREQ_HZ),
    .MODULUS (pwr_pkg::CLK_FREQ_HZ)
  ) u_osc_tick (
    .clk  (CLOCK),
    .rst  (RST),
    .run  (osc_on && osc_stable_r),
    .tick (osc_tick)
  );

  rate_tick #(
    .INC     (pwr_pkg::PLL_FREQ_HZ),
    .MODULUS (pwr_pkg::CLK_FREQ_HZ)
  ) u_pll_tick (
    .clk  (CLOCK),
    .rst  (RST),
    .run  (pll_on),
    .tick (pll_tick)
  );

  // wake conditions
  assign idle_wake = IRQ_PENDING;
  always_comb
  begin
    pd_wake = 1'b0;
    if (osc_on && INTV_EN && INTV_IRQ)
      pd_wake = 1'b1;
    if (pwrctl_r.serial_wake && SPI_IRQ_EN && SPI_IRQ)
      pd_wake = 1'b1;
    if (pwrctl_r.int0_wake && INT0_IRQ_EN && INT0_IRQ)
      pd_wake = 1'b1;
  end

  assign wake = ((state_r == pwr_pkg::ST_IDLE) && idle_wake) ||
                ((state_r == pwr_pkg::ST_PDOWN) && pd_wake);

  // mode sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      pwr_pkg::ST_POR:
        if (supply_ok && por_cnt_r == PW'(POR_CNT))
          state_nxt = reset_pin ? pwr_pkg::ST_RESET : pwr_pkg::ST_NORMAL;
      pwr_pkg::ST_RESET:
        if (!reset_pin)
          state_nxt = pwr_pkg::ST_NORMAL;
      pwr_pkg::ST_NORMAL:
        if (pwrctl_r.pdown)
          state_nxt = pwr_pkg::ST_PDOWN;
        else if (pwrctl_r.idle)
          state_nxt = pwr_pkg::ST_IDLE;
      pwr_pkg::ST_IDLE:
        if (idle_wake)
          state_nxt = pwr_pkg::ST_NORMAL;
      pwr_pkg::ST_PDOWN:
        if (pd_wake)
          state_nxt = pwr_pkg::ST_NORMAL;
      default:
        state_nxt = pwr_pkg::ST_POR;
    endcase
    if (!supply_ok)
      state_nxt = pwr_pkg::ST_POR;
    else if (reset_pin && state_r != pwr_pkg::ST_POR)
      state_nxt = pwr_pkg::ST_RESET;
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
      state_r <= pwr_pkg::ST_POR;
    else
      state_r <= state_nxt;
  end

  // power-on delay counter
  always_ff @(posedge CLOCK)
  begin
    if (RST || state_r != pwr_pkg::ST_POR || !supply_ok)
      por_cnt_r <= '0;
    else if (por_cnt_r != PW'(POR_CNT))
      por_cnt_r <= por_cnt_r + PW'(1);
  end

  // power control register; wake clears the mode request bits
  always_ff @(posedge CLOCK)
  begin
    if (RST || in_reset)
      pwrctl_r <= pwr_pkg::PWRCTL_RESET[6:0];
    else if (wake)
    begin
      pwrctl_r.idle  <= 1'b0;
      pwrctl_r.pdown <= 1'b0;
    end
    else if (pwrctl_wr && state_r == pwr_pkg::ST_NORMAL)
      pwrctl_r <= SFR_WDATA[6:0];
  end

  // clock multiplier control register
  always_ff @(posedge CLOCK)
  begin
    if (RST || in_reset)
    begin
      clkmul_r.oscillator_powerdown_bit   <= pwr_pkg::OSCPD_RESET;
      clkmul_r.core_div <= pwr_pkg::PLL_CD_RESET;
    end
    else if (clkmul_wr && state_r == pwr_pkg::ST_NORMAL)
    begin
      clkmul_r.oscillator_powerdown_bit   <= SFR_WDATA[pwr_pkg::PLL_OSCPD_BIT];
      clkmul_r.core_div <= SFR_WDATA[pwr_pkg::PLL_CD_LSB +: 3];
    end
  end

  // oscillator start-up after it was stopped
  always_ff @(posedge CLOCK)
  begin
    if (RST || !osc_on)
    begin
      osc_cnt_r    <= '0;
      osc_stable_r <= 1'b0;
    end
    else if (osc_cnt_r == OW'(OSC_START_CNT))
      osc_stable_r <= 1'b1;
    else
      osc_cnt_r <= osc_cnt_r + OW'(1);
  end

  // multiplier lock timer, starts once the oscillator is stable
  always_ff @(posedge CLOCK)
  begin
    if (RST || !pll_on || !osc_stable_r)
    begin
      lock_cnt_r <= '0;
      lock_r     <= 1'b0;
    end
    else if (lock_cnt_r == LW'(LOCK_CNT))
      lock_r <= 1'b1;
    else
      lock_cnt_r <= lock_cnt_r + LW'(1);
  end

  // core clock divider; core runs before lock at an unspecified rate
  always_ff @(posedge CLOCK)
  begin
    if (RST || in_reset)
      div_cnt_r <= 8'h0;
    else if (pll_tick)
      div_cnt_r <= div_cnt_r + 8'h1;
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      core_en_r   <= 1'b0;
      periph_en_r <= 1'b0;
    end
    else
    begin
      core_en_r   <= pll_tick && (state_r == pwr_pkg::ST_NORMAL) &&
                     ((div_cnt_r & ((8'h1 << clkmul_r.core_div) - 8'h1)) == 8'h0);
      periph_en_r <= pll_tick && !in_reset &&
                     (state_r != pwr_pkg::ST_PDOWN);
    end
  end

  // one-cycle wake notice to the core for interrupt service
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      wake_r <= 1'b0;
    else
      wake_r <= wake && !reset_pin;
  end

  // core reset and strap capture at reset release
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      core_rst_r <= 1'b1;
    else
      core_rst_r <= (state_nxt == pwr_pkg::ST_POR) || (state_nxt == pwr_pkg::ST_RESET);
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
      download_r <= 1'b0;
    else if (in_reset && state_nxt == pwr_pkg::ST_NORMAL)
      download_r <= !pstrb_in;
  end

  // pin behaviour per mode
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      pins_r.pstrb_o    <= 1'b1;
      pins_r.pstrb_oe_n <= 1'b1;
      pins_r.ale_o      <= 1'b0;
      pins_r.dac_oe_n   <= 1'b0;
      pins_r.port_hold  <= 1'b0;
    end
    else
    begin
      case (state_r)
        pwr_pkg::ST_POR, pwr_pkg::ST_RESET:
        begin
          pins_r.pstrb_o    <= 1'b1;
          pins_r.pstrb_oe_n <= 1'b1;
          pins_r.ale_o      <= 1'b0;
          pins_r.dac_oe_n   <= 1'b0;
          pins_r.port_hold  <= 1'b0;
        end
        pwr_pkg::ST_IDLE:
        begin
          pins_r.pstrb_o    <= 1'b1;
          pins_r.pstrb_oe_n <= 1'b0;
          pins_r.ale_o      <= 1'b1;
          pins_r.dac_oe_n   <= 1'b0;
          pins_r.port_hold  <= 1'b1;
        end
        pwr_pkg::ST_PDOWN:
        begin
          pins_r.pstrb_o    <= 1'b0;
          pins_r.pstrb_oe_n <= 1'b0;
          pins_r.ale_o      <= 1'b0;
          pins_r.dac_oe_n   <= 1'b1;
          pins_r.port_hold  <= 1'b1;
        end
        default:
        begin
          pins_r.pstrb_o    <= CORE_PSTRB;
          pins_r.pstrb_oe_n <= 1'b0;
          pins_r.ale_o      <= CORE_ALE;
          pins_r.dac_oe_n   <= 1'b0;
          pins_r.port_hold  <= 1'b0;
        end
      endcase
    end
  end

  // register read port
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      rdata_r <= 8'h00;
    else if (SFR_RD)
    begin
      if (sfr_hit(SFR_ADDR, pwr_pkg::IDENT_ADDR))
        rdata_r <= {FAMILY_CODE, REVISION};
      else if (sfr_hit(SFR_ADDR, pwr_pkg::PWRCTL_ADDR))
        rdata_r <= {1'b0, pwrctl_r};
      else if (sfr_hit(SFR_ADDR, pwr_pkg::CLKMUL_ADDR))
      begin
        rdata_r <= 8'h00;
        rdata_r[pwr_pkg::PLL_OSCPD_BIT] <= clkmul_r.oscillator_powerdown_bit;
        rdata_r[pwr_pkg::PLL_LOCK_BIT]  <= lock_r;
        rdata_r[pwr_pkg::PLL_CD_LSB +: 3] <= clkmul_r.core_div;
      end
      else
        rdata_r <= 8'h00;
    end
  end

  assign SFR_RDATA     = rdata_r;
  assign PSTRB_O       = pins_r.pstrb_o;
  assign PSTRB_OE_N    = pins_r.pstrb_oe_n;
  assign ALE_O         = pins_r.ale_o;
  assign DAC_OE_N      = pins_r.dac_oe_n;
  assign PORT_HOLD     = pins_r.port_hold;
  assign CORE_RST      = core_rst_r;
  assign CORE_CLK_EN   = core_en_r;
  assign PERIPH_CLK_EN = periph_en_r;
  assign OSC_TICK      = osc_tick;
  assign OSC_RUN       = osc_stable_r;
  assign PLL_RUN       = pll_on;
  assign PLL_LOCK      = lock_r;
  assign WAKE_PULSE    = wake_r;
  assign DOWNLOAD_MODE = download_r;
  assign MODE          = state_r;

endmodule

// ===== verification/power_mode_wake_control_assertions.sv
// concurrent checks on the power-mode and wake controller ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
module power_mode_wake_control_assertions #(
  parameter logic [3:0] FAMILY_CODE = 4'hA
) (
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic       SFR_WR,
  input wire logic       SFR_RD,
  input wire logic [7:0] SFR_RDATA,
  input wire logic       IRQ_PENDING,
  input wire logic       PSTRB_O,
  input wire logic       ALE_O,
  input wire logic       DAC_OE_N,
  input wire logic       PORT_HOLD,
  input wire logic       CORE_CLK_EN,
  input wire logic       PERIPH_CLK_EN,
  input wire logic       PLL_RUN,
  input wire logic       PLL_LOCK,
  input wire logic       WAKE_PULSE,
  input wire logic       DOWNLOAD_MODE,
  input wire logic [2:0] MODE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence power_control_reg_wr_s;
    SFR_WR && SFR_ADDR == pwr_pkg::PWRCTL_ADDR && MODE == 3'h2;
  endsequence
  sequence woke_s;
    MODE == 3'h2 && WAKE_PULSE ##1 !WAKE_PULSE;
  endsequence
  idle_entry_a: assert property (power_control_reg_wr_s and SFR_WDATA[1:0] == 2'b01 |-> ##2 MODE == 3'h3)
    else $error("idle request did not reach idle");
  pd_entry_a: assert property (power_control_reg_wr_s and SFR_WDATA[1] |-> ##2 MODE == 3'h4)
    else $error("power-down request did not reach power-down");
  idle_pins_a: assert property (MODE == 3'h3 && $past(MODE) == 3'h3
    |-> ALE_O && PSTRB_O && PORT_HOLD && !CORE_CLK_EN)
    else $error("idle pins or core clock wrong");
  pd_pins_a: assert property (MODE == 3'h4 && $past(MODE) == 3'h4 |-> !ALE_O && !PSTRB_O && DAC_OE_N && PORT_HOLD)
    else $error("power-down pins wrong");
  pd_clocks_a: assert property (MODE == 3'h4 && $past(MODE) == 3'h4
    |-> !PLL_RUN && !CORE_CLK_EN && !PERIPH_CLK_EN && !PLL_LOCK)
    else $error("clocks running in power-down");
  idle_wake_a: assert property (MODE == 3'h3 && IRQ_PENDING |=> woke_s)
    else $error("idle not left on pending interrupt");
  wake_src_a: assert property ($rose(WAKE_PULSE) |-> $past(MODE) == 3'h3 || $past(MODE) == 3'h4)
    else $error("wake pulse outside a low-power mode");
  ident_read_a: assert property (SFR_RD && SFR_ADDR == pwr_pkg::IDENT_ADDR && MODE == 3'h2
    |=> SFR_RDATA[7:4] == FAMILY_CODE)
    else $error("identity nibble wrong");
  lock_read_a: assert property (SFR_RD && SFR_ADDR == pwr_pkg::CLKMUL_ADDR && MODE == 3'h2
    |=> SFR_RDATA[6] == PLL_LOCK || SFR_RDATA[6] == $past(PLL_LOCK))
    else $error("lock bit does not follow lock");
  strap_hold_a: assert property (MODE == 3'h2 && $past(MODE) == 3'h2 |-> $stable(DOWNLOAD_MODE))
    else $error("strap result changed while running");
endmodule
bind power_mode_wake_control power_mode_wake_control_assertions #(.FAMILY_CODE(FAMILY_CODE)) checker_i (
  .CLOCK(CLOCK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
  .SFR_RDATA(SFR_RDATA), .IRQ_PENDING(IRQ_PENDING), .PSTRB_O(PSTRB_O), .ALE_O(ALE_O), .DAC_OE_N(DAC_OE_N),
  .PORT_HOLD(PORT_HOLD), .CORE_CLK_EN(CORE_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN), .PLL_RUN(PLL_RUN),
  .PLL_LOCK(PLL_LOCK), .WAKE_PULSE(WAKE_PULSE), .DOWNLOAD_MODE(DOWNLOAD_MODE), .MODE(MODE));

// ===== verification/wake_sources.sv
// model of supply, reset pin, strap jumper and interrupt sources
// assumes the block's clock; changes land just after a rising edge
`timescale 1ns/100ps
module wake_sources (
  input  wire logic  clock,
  input  wire logic  wake_pulse,
  input  wire logic  pstrb_o,
  input  wire logic  pstrb_oe_n,
  output logic       supply_ok,
  output logic       reset_pin,
  output logic       pstrb_i,
  output logic       irq_pending,
  output logic [2:0] irq,
  output logic       irq_en
);
  logic jumper;
  initial
  begin
    supply_ok = 1'b1;
    reset_pin = 1'b0;
    jumper = 1'b0;
    irq = 3'h0;
    irq_en = 1'b1;
  end
  // pin level: device drive, else jumper low, else pull-up
  assign pstrb_i = !pstrb_oe_n ? pstrb_o : !jumper;
  assign irq_pending = |irq && irq_en;
  // raise a source after lat cycles; drop it on wake or after hold cycles
  task automatic fire(input int src, input int lat, input int hold);
    repeat (lat) @(posedge clock);
    #1 irq[src] = 1'b1;
    for (int i = 0; i < hold; i++)
    begin
      @(posedge clock);
      #1;
      if (wake_pulse)
        break;
    end
    irq[src] = 1'b0;
  endtask
  // reset pin pulse or supply dip, with the strap jumper set as asked
  task automatic disturb(input logic pin, input logic jmp);
    jumper = jmp;
    if (pin)
      reset_pin = 1'b1;
    else
      supply_ok = 1'b0;
    repeat (10) @(posedge clock);
    #1 reset_pin = 1'b0;
    supply_ok = 1'b1;
  endtask
endmodule

// ===== verification/testbench.sv
// self-checking bench for the power-mode and wake controller
// assumes the partner model drives supply, reset pin, strap and interrupts
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; $display("FAIL %s exp %0h got %0h", n, e, a); end end
module testbench;
  localparam int POR = 50;
  localparam int LK = 20;
  localparam int OS = 30;
  localparam logic [3:0] FAM = 4'h5; // arbitrary value
  localparam logic [3:0] REV = 4'h2; // arbitrary value
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic [2:0] irq;
  logic [2:0] mode;
  logic       irq_en, supply_ok, reset_pin, pstrb_i, irq_pending, pstrb_o, pstrb_oe_n, ale_o, dac_oe_n;
  logic       port_hold, core_clk_en, periph_clk_en, osc_run, pll_run, pll_lock, wake_pulse, download_mode;
  logic       core_rst;
  int         fails = 0;
  int         checked = 0;
  always #5 clock = !clock;
  wake_sources wake_sources_i (.clock(clock), .wake_pulse(wake_pulse), .pstrb_o(pstrb_o), .pstrb_oe_n(pstrb_oe_n),
    .supply_ok(supply_ok), .reset_pin(reset_pin), .pstrb_i(pstrb_i), .irq_pending(irq_pending), .irq(irq),
    .irq_en(irq_en));
  power_mode_wake_control #(.POR_CNT(POR), .LOCK_CNT(LK), .OSC_START_CNT(OS), .FAMILY_CODE(FAM), .REVISION(REV))
    power_mode_wake_control_i (.CLOCK(clock), .RST(rst), .SUPPLY_OK(supply_ok), .RESET_PIN(reset_pin),
    .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_RDATA(sfr_rdata),
    .IRQ_PENDING(irq_pending), .INTV_EN(irq_en), .INTV_IRQ(irq[0]), .SPI_IRQ_EN(irq_en), .SPI_IRQ(irq[1]),
    .INT0_IRQ_EN(irq_en), .INT0_IRQ(irq[2]), .CORE_PSTRB(1'b0), .CORE_ALE(1'b0), .PSTRB_I(pstrb_i),
    .PSTRB_O(pstrb_o), .PSTRB_OE_N(pstrb_oe_n), .ALE_O(ale_o), .DAC_OE_N(dac_oe_n), .PORT_HOLD(port_hold),
    .CORE_RST(core_rst), .CORE_CLK_EN(core_clk_en), .PERIPH_CLK_EN(periph_clk_en), .OSC_TICK(), .OSC_RUN(osc_run),
    .PLL_RUN(pll_run), .PLL_LOCK(pll_lock), .WAKE_PULSE(wake_pulse), .DOWNLOAD_MODE(download_mode), .MODE(mode));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    cyc(1);
    d = sfr_rdata;
  endtask
  task automatic wait_mode(input logic [2:0] m, input int lim, output int n);
    n = 0;
    while (mode !== m && n < lim)
    begin
      cyc(1);
      n++;
    end
    `CHK("mode", m, mode)
  endtask
  task automatic enter(input logic [7:0] ctl, input logic [2:0] m);
    wr(pwr_pkg::PWRCTL_ADDR, ctl);
    cyc(3);
    `CHK("entry", m, mode)
    `CHK("ale", m == 3'h3, ale_o)
    `CHK("pstrb", m == 3'h3, pstrb_o)
    `CHK("dac float", m == 3'h4, dac_oe_n)
  endtask
  task automatic woke(input int lo);
    logic [7:0] d;
    int n;
    `CHK("woken", 3'h2, mode)
    rd(pwr_pkg::PWRCTL_ADDR, d);
    `CHK("mode bits", 2'b00, d[1:0])
    rd(pwr_pkg::CLKMUL_ADDR, d);
    `CHK("lock early", 1'b0, d[6])
    wait_mode(3'h2, 1, n);
    while (pll_lock !== 1'b1 && n < lo + 20)
    begin
      cyc(1);
      n++;
    end
    `CHK("lock time", 1'b1, n >= lo - 8 && n <= lo + 2)
    rd(pwr_pkg::CLKMUL_ADDR, d);
    `CHK("lock bit", 1'b1, d[6])
  endtask
  task automatic t_ident;
    logic [7:0] d;
    rd(pwr_pkg::IDENT_ADDR, d);
    `CHK("identity", {FAM, REV}, d)
    wr(pwr_pkg::IDENT_ADDR, 8'h00);
    rd(pwr_pkg::IDENT_ADDR, d);
    `CHK("identity ro", {FAM, REV}, d)
    rd(8'h00, d);
    `CHK("unmapped", 8'h00, d)
    $display("test ident done");
  endtask
  task automatic t_idle;
    int cc, pc, ex;
    cc = 0;
    pc = 0;
    ex = int'(longint'(pwr_pkg::PLL_FREQ_HZ) * 1000 / pwr_pkg::CLK_FREQ_HZ);
    enter(8'h01, 3'h3);
    repeat (1000)
    begin
      cyc(1);
      cc += int'(core_clk_en);
      pc += int'(periph_clk_en);
    end
    `CHK("core gated", 0, cc)
    `CHK("periph rate", 1'b1, pc >= ex && pc <= ex + 1)
    wake_sources_i.fire(1, 3, 10);
    `CHK("idle wake", 3'h2, mode)
    $display("test idle done");
  endtask
  task automatic t_wake;
    for (int s = 1; s <= 2; s++)
    begin
      enter(8'h02, 3'h4);
      `CHK("osc kept", 1'b1, osc_run)
      wake_sources_i.fire(s, 0, 15);
      `CHK("no wake", 3'h4, mode)
      wake_sources_i.fire(0, 0, 15);
      woke(LK);
      enter(8'h03 | (8'h01 << (s + 4)), 3'h4);
      wake_sources_i.fire(s, 2, 15);
      woke(LK);
    end
    $display("test wake done");
  endtask
  task automatic t_oscpd;
    wr(pwr_pkg::CLKMUL_ADDR, 8'h83);
    enter(8'h42, 3'h4);
    `CHK("osc stopped", 1'b0, osc_run)
    wake_sources_i.fire(0, 0, 15);
    `CHK("tic no wake", 3'h4, mode)
    wake_sources_i.fire(2, 1, 15);
    woke(LK + OS);
    wr(pwr_pkg::CLKMUL_ADDR, 8'h03);
    $display("test oscillator done");
  endtask
  task automatic t_reset;
    logic [7:0] d;
    int n;
    for (int k = 0; k < 3; k++)
    begin
      enter(8'h22, 3'h4);
      wake_sources_i.disturb(k != 2, k == 0);
      wait_mode(3'h2, POR + 20, n);
      if (k == 2)
        `CHK("por time", 1'b1, n >= POR - 12 && n <= POR + 8)
      `CHK("download", k == 0, download_mode)
      `CHK("core released", 1'b0, core_rst)
      rd(pwr_pkg::PWRCTL_ADDR, d);
      `CHK("power ctl default", pwr_pkg::PWRCTL_RESET, d)
      rd(pwr_pkg::CLKMUL_ADDR, d);
      `CHK("divider default", pwr_pkg::PLL_CD_RESET, d[2:0])
      while (pll_lock !== 1'b1 && n < 500)
      begin
        cyc(1);
        n++;
      end
    end
    $display("test reset done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #400000;
    fails++;
    results();
  end
  initial
  begin
    int n;
    cyc(2);
    rst = 1'b0;
    wait_mode(3'h2, POR + 20, n);
    while (pll_lock !== 1'b1 && n < 500)
    begin
      cyc(1);
      n++;
    end
    t_ident();
    t_idle();
    t_wake();
    t_oscpd();
    t_reset();
    results();
  end
endmodule
